// ### bench/smbus_charger_control_slave_properties.sv
// port assertions for the charger slave
// assumes a bind onto smbus_charger_control_slave
`default_nettype none

module smbus_charger_control_slave_properties #(
	parameter int unsigned scl_timeout = 200
) (
	input wire logic                  core_clk,
	input wire logic                  rst,
	input wire logic                  scl,
	input wire logic                  sda_oe,
	input wire logic                  interface_supply,
	input wire charger_pkg::sense_t   sense,
	input wire logic                  adapter_present_n_oe,
	input wire charger_pkg::charge_cmd_t charge_cmd
);
	import charger_pkg::*;

	logic [31:0] low_q;
	logic [31:0] low_d;

	always_comb low_d = scl ? 32'h0 : low_q + 32'h1;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) low_q <= 32'h0;
		else low_q <= low_d;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	sequence s_low;   sense.batt_low [*6];     endsequence
	sequence s_hot;   sense.temp_hot [*6];     endsequence
	sequence s_fall;  sense.adapter_fall [*6]; endsequence
	sequence s_rise;  sense.adapter_rise [*6]; endsequence
	sequence s_volt;  sense.at_volt [*6];      endsequence
	sequence s_lim;   sense.at_in_limit [*6];  endsequence
	sequence s_nosup; !interface_supply [*8];  endsequence

	chk_reset_quiet: assert property (disable iff (1'b0) rst |->
		!sda_oe && adapter_present_n_oe && !charge_cmd.enable)
		else $error("outputs active in reset");
	chk_trickle_cap: assert property (s_low |->
		charge_cmd.current <= trickle_current) else $error("no cap");
	chk_hot_stop: assert property (s_hot |-> !charge_cmd.enable)
		else $error("charging while hot");
	chk_adapter_low: assert property (s_fall |-> adapter_present_n_oe)
		else $error("adapter pin released");
	chk_adapter_high: assert property (s_rise |-> !adapter_present_n_oe)
		else $error("adapter pin held");
	chk_volt_mode: assert property (s_volt ##0 $past(charge_cmd.enable) &&
		charge_cmd.enable |-> charge_cmd.const_volt) else $error("no cv");
	chk_input_limit: assert property (s_lim ##0 $past(charge_cmd.enable) &&
		charge_cmd.enable |-> charge_cmd.throttle) else $error("no cut");
	chk_supply_nak: assert property (s_nosup |-> !sda_oe)
		else $error("ack while not ready");
	chk_scl_timeout: assert property (low_q == scl_timeout + 8 |->
		!charge_cmd.enable) else $error("no scl timeout");
	chk_field_mask: assert property (charge_cmd.enable |->
		(charge_cmd.voltage & ~volt_field_mask) == 16'h0000)
		else $error("voltage field");
endmodule : smbus_charger_control_slave_properties

`default_nettype wire

// ### bench/smbus_host.sv
// smbus host model: drives scl, pulls sda low when sending a 0
// assumes sda is pulled up outside and read back on sda
`default_nettype none

module smbus_host (
	output logic      scl,
	output logic      pull,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	import charger_pkg::*;

	int errs = 0;

	initial begin
		scl  = 1'b1;
		pull = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	task bit_w(input logic b);
		#12 pull = !b;
		#12 scl = 1'b1;
		#24 scl = 1'b0;
	endtask : bit_w

	task bit_r(output logic b);
		#12 pull = 1'b0;
		#12 scl = 1'b1;
		b = sda;
		#23 if (sda !== b) errs++;
		#1 scl = 1'b0;
	endtask : bit_r

	task start;
		#12 pull = 1'b0;
		#12 scl = 1'b1;
		#12 pull = 1'b1;
		#12 scl = 1'b0;
	endtask : start

	task stop;
		#12 pull = 1'b1;
		#12 scl = 1'b1;
		#12 pull = 1'b0;
		#24;
	endtask : stop

	task hold(input logic v);
		scl = v;
	endtask : hold

	////////////////////////////////////////////////////////////////////////
	task byte_w(input logic [7:0] d, output logic k);
		for (int i = 7; i >= 0; i--) bit_w(d[i]);
		bit_r(k);
	endtask : byte_w

	task byte_r(output logic [7:0] d, input logic nak);
		for (int i = 7; i >= 0; i--) bit_r(d[i]);
		bit_w(nak);
	endtask : byte_r

	task wr(input logic [6:0] a, input logic [7:0] r,
		input logic [15:0] d, input logic full, output logic [3:0] k);
		start();
		byte_w({a, 1'b0}, k[3]);
		byte_w(r, k[2]);
		byte_w(d[7:0], k[1]);
		k[0] = 1'b1;
		if (full) byte_w(d[15:8], k[0]);
		stop();
	endtask : wr

	task rd(input logic [7:0] r, output logic [15:0] d,
		output logic [2:0] k);
		start();
		byte_w({slave_addr, 1'b0}, k[2]);
		byte_w(r, k[1]);
		start();
		byte_w({slave_addr, 1'b1}, k[0]);
		byte_r(d[7:0], 1'b0);
		byte_r(d[15:8], 1'b1);
		stop();
	endtask : rd
endmodule : smbus_host

`default_nettype wire

// ### bench/tb_smbus_charger_control_slave.sv
// self-checking bench for the charger slave
// assumes the host model and the bound port checker
`default_nettype none

module tb_smbus_charger_control_slave;
	timeunit 1ns;
	timeprecision 1ns;
	import charger_pkg::*;

	localparam int unsigned     to_c = 200;
	localparam longint unsigned wd_c = 3000;
	logic        core_clk = 1'b0;
	logic        rst      = 1'b0;
	logic        supply   = 1'b1;
	sense_t      sense;
	logic        scl, pull, sda_oe, ap_oe;
	charge_cmd_t cmd;
	wire logic   sda = !(pull || sda_oe);
	int          failures = 0;
	int          n_checks = 0;
	int          cyc = 0;
	logic [15:0] d;
	logic [3:0]  k;
	logic [2:0]  kr;
	logic [7:0]  regs [5] = '{reg_chg_current, reg_chg_voltage,
		reg_in_current, reg_maker_id, reg_part_id};
	logic [15:0] por [5] = '{por_chg_current, por_chg_voltage,
		por_in_current, maker_code, part_code};
	logic [15:0] wv [3] = '{16'h0F80, 16'h41A0, 16'h0F80};
	logic [7:0]  sv [12] = '{8'h54, 8'h94, 8'h14, 8'h54, 8'h64, 8'h44,
		8'h54, 8'h58, 8'h50, 8'h54, 8'h56, 8'h55};
	logic [3:0]  ev [12] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h0, 4'h0,
		4'h8, 4'h4, 4'h4, 4'h8, 4'hA, 4'h9};

	always #50 core_clk = !core_clk;

	smbus_host host (.scl(scl), .pull(pull), .sda(sda));

	smbus_charger_control_slave #(.scl_timeout(to_c), .watchdog(wd_c)) DUT (
		.core_clk(core_clk), .rst(rst), .scl(scl), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe), .interface_supply(supply),
		.sense(sense), .adapter_present_n_out(),
		.adapter_present_n_oe(ap_oe), .charge_cmd(cmd));

	////////////////////////////////////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 10000) begin
			failures++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst   = 1'b1;
		sense = 8'h54;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		repeat (3) @(negedge core_clk);
		for (int i = 0; i < 5; i++) begin
			host.rd(regs[i], d, kr);
			check(d, por[i]);
			check({13'h0, kr}, 16'h0);
		end
		for (int i = 0; i < 3; i++) begin
			host.wr(slave_addr, regs[i], wv[i], 1'b1, k);
			check({12'h0, k}, 16'h0);
			host.rd(regs[i], d, kr);
			check(d, wv[i]);
		end
		host.wr(7'h08, reg_chg_current, 16'h1F80, 1'b1, k);
		check({12'h0, k}, 16'h000F);
		host.wr(slave_addr, reg_chg_current, 16'h0080, 1'b0, k);
		check({12'h0, k}, 16'h0001);
		host.rd(reg_chg_current, d, kr);
		check(d, 16'h0F80);
		@(negedge core_clk) supply = 1'b0;
		repeat (5) @(negedge core_clk);
		host.wr(slave_addr, reg_chg_current, 16'h1F80, 1'b1, k);
		check({12'h0, k}, 16'h000F);
		@(negedge core_clk) supply = 1'b1;
		repeat (5) @(negedge core_clk);
		check(cmd.voltage, 16'h41A0);
		for (int i = 0; i < 12; i++) begin
			@(negedge core_clk) sense = sv[i];
			repeat (10) @(negedge core_clk);
			check({12'h0, cmd.enable, ap_oe, cmd.const_volt, cmd.throttle},
				{12'h0, ev[i]});
			if (ev[i][3]) check(cmd.current,
				(i == 1 || i == 2) ? trickle_current : 16'h0F80);
		end
		host.hold(1'b0);
		repeat (to_c + 20) @(negedge core_clk);
		check({15'h0, cmd.enable}, 16'h0);
		host.hold(1'b1);
		repeat (10) @(negedge core_clk);
		check({15'h0, cmd.enable}, 16'h1);
		repeat (wd_c + 100) @(negedge core_clk);
		check({15'h0, cmd.enable}, 16'h0);
		check(16'(host.errs), 16'h0);
		finish_test();
	end
endmodule : tb_smbus_charger_control_slave

bind smbus_charger_control_slave smbus_charger_control_slave_properties #(
	.scl_timeout(scl_timeout)
) chk (
	.core_clk(core_clk), .rst(rst), .scl(scl), .sda_oe(sda_oe),
	.interface_supply(interface_supply), .sense(sense),
	.adapter_present_n_oe(adapter_present_n_oe), .charge_cmd(charge_cmd));

`default_nettype wire

// ### verilog/bit_sync.sv
// two-stage synchroniser for a level
// assumes the input is asynchronous to clk
`default_nettype none

module bit_sync #(
	parameter logic init = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);

	typedef struct packed {
		logic s1;
		logic s2;
	} sync_t;

	sync_t q, d;

	always_comb begin
		d    = q;
		d.s1 = din;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= {init, init};
		end else begin
			q <= d;
		end
	end

	assign dout = q.s2;

endmodule : bit_sync

`default_nettype wire

// ### verilog/charger_pkg.sv
// constants, field layouts and carriers for the smbus charger slave
// assumes a core clock of 10 MHz and an scl domain clocked by the bus clock
//
// Function
// - sda driven only changes while scl is low, except start/stop
// - each byte takes nine clocks: eight data, one acknowledge
// - on matching address the device pulls sda low in ninth clock
// - only slave address 0001001 is answered, all others ignored
// - direction bit 0 means write, 1 means read
// - no match or not ready leaves sda released in acknowledge slot
// - device acknowledges register address and holds it as target
// - receiver acknowledges each register address and data byte
// - setting registers kept while interface supply is powered
// - sense below 2.5V caps current at 128mA; restored above 2.7V
// - stop charging above 150C, resume below 125C
// - adapter present output low below falling, released above rising
// - regulate to current setting, then voltage; cut at input limit
// - bytes go most significant bit first
// - decode 0x14, 0x15, 0x3F read/write plus two identity registers
// - scl low beyond the 22 to 30 ms window disables the charger
// - no voltage or current write in 140 to 220 s stops charging
`default_nettype none

package charger_pkg;

	localparam logic [6:0]  slave_addr      = 7'h09;
	localparam logic [7:0]  reg_chg_current = 8'h14;
	localparam logic [7:0]  reg_chg_voltage = 8'h15;
	localparam logic [7:0]  reg_in_current  = 8'h3F;
	localparam logic [7:0]  reg_maker_id    = 8'hFE;
	localparam logic [7:0]  reg_part_id     = 8'hFF;
	// identity words: arbitrary values, not taken from any part
	localparam logic [15:0] maker_code      = 16'h00A5;
	localparam logic [15:0] part_code       = 16'h005A;
	localparam logic [15:0] por_chg_current = 16'h0000;
	localparam logic [15:0] por_chg_voltage = 16'h0000;
	localparam logic [15:0] por_in_current  = 16'h0080;
	localparam logic [15:0] trickle_current = 16'h0080;
	localparam logic [15:0] cur_field_mask  = 16'h1F80;
	localparam logic [15:0] volt_field_mask = 16'h7FF0;
	localparam logic [15:0] min_chg_current = 16'h007F;
	localparam logic [15:0] min_chg_voltage = 16'h000F;

	localparam int unsigned clk_hz         = 10_000_000;
	localparam int unsigned scl_timeout_ms = 22;
	localparam int unsigned scl_timeout_cycles =
		scl_timeout_ms * (clk_hz / 1000);
	localparam int unsigned watchdog_s     = 140;
	localparam longint unsigned watchdog_cycles =
		longint'(watchdog_s) * longint'(clk_hz);

	typedef struct packed {
		logic        valid;
		logic [7:0]  index;
		logic [15:0] data;
	} reg_write_t;

	typedef struct packed {
		logic        batt_low;
		logic        batt_ok;
		logic        temp_hot;
		logic        temp_cool;
		logic        adapter_fall;
		logic        adapter_rise;
		logic        at_volt;
		logic        at_in_limit;
	} sense_t;

	typedef struct packed {
		logic        enable;
		logic [15:0] current;
		logic [15:0] voltage;
		logic        const_volt;
		logic        throttle;
	} charge_cmd_t;

endpackage : charger_pkg

`default_nettype wire

// ### verilog/smbus_charger_control_slave.sv
// charger settings registers and charge supervision
// assumes scl and sda come from pins; sense comparators give digital levels
`default_nettype none

module smbus_charger_control_slave #(
	parameter int unsigned scl_timeout = charger_pkg::scl_timeout_cycles,
	parameter longint unsigned watchdog = charger_pkg::watchdog_cycles
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 scl,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe,
	input  wire logic                 interface_supply,
	input  wire charger_pkg::sense_t  sense,
	output logic                      adapter_present_n_out,
	output logic                      adapter_present_n_oe,
	output charger_pkg::charge_cmd_t  charge_cmd
);
	import charger_pkg::*;

	logic        link_oe, link_tg, tg_s, scl_s, supply_s;
	reg_write_t  link_wr;
	logic [47:0] rd_words;
	sense_t      sense_s;

	typedef struct packed {
		logic [15:0] cur;
		logic [15:0] volt;
		logic [15:0] inlim;
		logic        tg_ack;
		logic [15:0] hold_data;
		logic [7:0]  hold_index;
		logic [31:0] scl_cnt;
		logic [39:0] wd_cnt;
		logic        scl_fault;
		logic        wd_fault;
		logic        trickle;
		logic        hot;
		logic        adapter_ok;
		logic        oe;
		charge_cmd_t cmd;
	} core_t;

	core_t q, d;

	////////////////////////////////////////////////////////////////////////
	// link in the scl domain
	smbus_link u_link (
		.scl       (scl),
		.rst       (rst),
		.sda_in    (sda_in),
		.ready     (supply_s),
		.rd_words  (rd_words),
		.sda_oe    (link_oe),
		.wr_toggle (link_tg),
		.wr_req    (link_wr)
	);

	////////////////////////////////////////////////////////////////////////
	// crossings into core_clk
	bit_sync #(.init(1'b0)) u_tg (
		.clk  (core_clk),
		.rst  (rst),
		.din  (link_tg),
		.dout (tg_s)
	);

	bit_sync #(.init(1'b1)) u_scl (
		.clk  (core_clk),
		.rst  (rst),
		.din  (scl),
		.dout (scl_s)
	);

	bit_sync #(.init(1'b0)) u_sup (
		.clk  (core_clk),
		.rst  (rst),
		.din  (interface_supply),
		.dout (supply_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < $bits(sense_t); gi++) begin : g_sense
			bit_sync #(.init(1'b0)) u_s (
				.clk  (core_clk),
				.rst  (rst),
				.din  (sense[gi]),
				.dout (sense_s[gi])
			);
		end
	endgenerate

	// read words change only through settled writes, a few core clocks after a write's high data byte
	assign rd_words = {q.inlim, q.volt, q.cur};

	////////////////////////////////////////////////////////////////////////
	// registers and supervision
	logic [15:0] eff_cur;

	always_comb begin
		d       = q;
		eff_cur = 16'h0000;
		// write request word is stable long before the toggle arrives
		if (tg_s != q.tg_ack) begin
			d.tg_ack = tg_s;
			if (link_wr.index == reg_chg_current) begin
				d.cur    = link_wr.data;
				d.wd_cnt = '0;
			end else if (link_wr.index == reg_chg_voltage) begin
				d.volt   = link_wr.data;
				d.wd_cnt = '0;
			end else if (link_wr.index == reg_in_current) begin
				d.inlim  = link_wr.data;
			end
			if (link_wr.index == reg_chg_current
					|| link_wr.index == reg_chg_voltage) begin
				d.wd_fault = 1'b0;
			end
		end else if (!q.wd_fault) begin
			if (q.wd_cnt >= 40'(watchdog - 1)) begin
				d.wd_fault = 1'b1;
			end else begin
				d.wd_cnt = q.wd_cnt + 40'h1;
			end
		end
		if (scl_s) begin
			d.scl_cnt   = '0;
			d.scl_fault = 1'b0;
		end else if (q.scl_cnt >= 32'(scl_timeout - 1)) begin
			d.scl_fault = 1'b1;
		end else begin
			d.scl_cnt = q.scl_cnt + 32'h1;
		end
		if (sense_s.batt_low) begin
			d.trickle = 1'b1;
		end else if (sense_s.batt_ok) begin
			d.trickle = 1'b0;
		end
		if (sense_s.temp_hot) begin
			d.hot = 1'b1;
		end else if (sense_s.temp_cool) begin
			d.hot = 1'b0;
		end
		if (sense_s.adapter_fall) begin
			d.adapter_ok = 1'b0;
		end else if (sense_s.adapter_rise) begin
			d.adapter_ok = 1'b1;
		end
		d.oe = !q.adapter_ok;
		eff_cur = q.cur & cur_field_mask;
		if (q.trickle && eff_cur > trickle_current) begin
			eff_cur = trickle_current;
		end
		d.cmd.current    = eff_cur;
		d.cmd.voltage    = q.volt & volt_field_mask;
		d.cmd.const_volt = sense_s.at_volt;
		d.cmd.throttle   = sense_s.at_in_limit;
		d.cmd.enable     = q.cur > min_chg_current
			&& q.volt > min_chg_voltage
			&& !q.hot && !q.scl_fault && !q.wd_fault && q.adapter_ok;
	end

	// registers reset only by rst; interface_supply loss is not a reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '{cur: por_chg_current, volt: por_chg_voltage,
				inlim: por_in_current, oe: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign sda_out               = 1'b0;
	assign sda_oe                = link_oe;
	assign adapter_present_n_out = 1'b0;
	assign adapter_present_n_oe  = q.oe;
	assign charge_cmd            = q.cmd;

endmodule : smbus_charger_control_slave

`default_nettype wire

// ### verilog/smbus_link.sv
// smbus bit and byte engine clocked by scl
// assumes the master drives scl; start/stop seen on sda edges with scl high
`default_nettype none

module smbus_link (
	input  wire logic                    scl,
	input  wire logic                    rst,
	input  wire logic                    sda_in,
	input  wire logic                    ready,
	input  wire logic [47:0]             rd_words,
	output logic                         sda_oe,
	output logic                         wr_toggle,
	output charger_pkg::reg_write_t      wr_req
);
	import charger_pkg::*;

	// start/stop detectors run on sda edges while scl high
	logic start_tg_q, stop_tg_q, start_seen_q, stop_seen_q;

	always_ff @(negedge sda_in or posedge rst) begin
		if (rst) begin
			start_tg_q <= 1'b0;
		end else if (scl) begin
			start_tg_q <= ~start_tg_q;
		end
	end

	always_ff @(posedge sda_in or posedge rst) begin
		if (rst) begin
			stop_tg_q <= 1'b0;
		end else if (scl) begin
			stop_tg_q <= ~stop_tg_q;
		end
	end

	typedef enum logic [4:0] {
		st_idle = 5'b00001,
		st_addr = 5'b00010,
		st_reg  = 5'b00100,
		st_wdat = 5'b01000,
		st_rdat = 5'b10000
	} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [3:0]  bitn;
		logic [7:0]  shift;
		logic        byten;
		logic [7:0]  index;
		logic [7:0]  lo;
		logic        tx;
		logic        selected;
		logic        start_ack;
		logic        stop_ack;
		logic        tg;
		reg_write_t  wr;
	} link_t;

	link_t q, d;
	logic  oe_q, oe_d;

	function automatic logic [15:0] pick(input logic [7:0] idx,
		input logic [47:0] w);
		if (idx == reg_chg_current) begin
			pick = w[15:0];
		end else if (idx == reg_chg_voltage) begin
			pick = w[31:16];
		end else if (idx == reg_in_current) begin
			pick = w[47:32];
		end else if (idx == reg_maker_id) begin
			pick = maker_code;
		end else if (idx == reg_part_id) begin
			pick = part_code;
		end else begin
			pick = 16'h0000;
		end
	endfunction : pick

	logic [15:0] rword;
	logic        fresh_start, fresh_stop;
	logic [7:0]  byte_in;

	always_comb begin
		d           = q;
		rword       = pick(q.index, rd_words);
		fresh_start = start_tg_q != q.start_ack;
		fresh_stop  = stop_tg_q != q.stop_ack;
		byte_in     = {q.shift[6:0], sda_in};
		d.wr.valid  = 1'b0;
		if (fresh_stop) begin
			d.stop_ack = stop_tg_q;
			d.phase    = st_idle;
			d.selected = 1'b0;
		end
		if (fresh_start) begin
			// the first rise after start already carries the address msb
			d.start_ack = start_tg_q;
			d.phase     = st_addr;
			d.bitn      = 4'h1;
			d.shift     = byte_in;
			d.byten     = 1'b0;
			d.tx        = 1'b0;
		end else if (q.phase != st_idle) begin
			if (q.bitn == 4'h8) begin
				d.bitn = 4'h0;
				if (q.tx) begin
					d.byten = ~q.byten;
					if (sda_in) begin
						d.selected = 1'b0;
					end
				end else if (q.phase == st_rdat) begin
					d.tx = 1'b1;
				end
			end else begin
				d.bitn = q.bitn + 4'h1;
				d.shift = byte_in;
			end
			if (q.bitn == 4'h7 && !q.tx) begin
				case (q.phase)
				st_addr: begin
					d.selected = ready && byte_in[7:1] == slave_addr;
					if (byte_in[0]) begin
						d.phase = st_rdat;
						d.byten = 1'b0;
					end else begin
						d.phase = st_reg;
					end
				end
				st_reg: begin
					if (q.selected) begin
						d.index = byte_in;
					end
					d.phase = st_wdat;
					d.byten = 1'b0;
				end
				st_wdat: begin
					if (!q.byten) begin
						d.lo    = byte_in;
						d.byten = 1'b1;
					end else if (q.selected) begin
						d.wr.valid = 1'b1;
						d.wr.index = q.index;
						d.wr.data  = {byte_in, q.lo};
						d.tg       = ~q.tg;
						d.byten    = 1'b0;
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	// sda changes on the falling edge of scl only
	always_comb begin
		oe_d = 1'b0;
		if (q.phase != st_idle && q.selected && !fresh_start
				&& !fresh_stop) begin
			if (q.bitn == 4'h8) begin
				oe_d = !q.tx;
			end else if (q.tx) begin
				oe_d = !rword[{q.byten, ~q.bitn[2:0]}];
			end
		end
	end

	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			q <= '{phase: st_idle, default: '0};
		end else begin
			q <= d;
		end
	end

	always_ff @(negedge scl or posedge rst) begin
		if (rst) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= oe_d;
		end
	end

	assign sda_oe    = oe_q;
	assign wr_toggle = q.tg;
	assign wr_req    = q.wr;

endmodule : smbus_link

`default_nettype wire
